// ===== design/sspc_device.sv
// Overview of operation
// - master keeps shift clock at most 8 MHz
// - master holds reset low at least 10 us
// - select stays high 1 us between frames
// - wait 5 us after reset before select
// - wait 500 ns from select to clock
// - serial output driven and released within 60 ns
// - software picks or disables sense pin source
// - direct inputs wake and, with pwm off, switch their outputs
// - external pwm clock arrives on input zero
// - fault flag low on fault; details serially
// - wake input high wakes the device
// - reset high wakes; low clears configuration
// - reset rising edge starts the watchdog
// - select fall loads status into shifter
// - select rise commits word to addressed register
// - select changes only while shift clock low
// - shift clock idles low while deselected
// - sample on falling edge, drive on rising
// - deselected: ignore clock and data, float output
// - sixteen bits per frame, msb first
// - five-bit address field picks the register
// - asleep, all settings read as zero
`timescale 1ns/1ps
module sspc_device
  import sspc_pkg::*;
#(
  parameter int WDOG_CYCLES = 65536
) (
  // core clock and power-on reset
  input  wire logic clk,
  input  wire logic arst_n,
  // link pins
  sspc_if.device    link,
  // analog and power stage hooks
  input  wire logic [3:0] faultIn,
  output logic      [3:0] switchOutputs,
  output logic      [2:0] senseSource,
  output logic            senseEnable,
  output logic            awake,
  output logic            wdExpired
);
  import sspc_pkg::*;

  localparam int WDW = $clog2(WDOG_CYCLES + 1);
  localparam logic [WDW-1:0] WDOG_LAST = WDW'(WDOG_CYCLES - 1);

  // select-fall domain: status snapshot and frame tag
  typedef struct packed {
    logic [15:0] snap;
    logic        frameTag;
  } sspc_open_t;

  // falling shift clock domain
  typedef struct packed {
    logic [15:0] sr;
    logic [4:0]  count;
    logic        seenTag;
  } sspc_rx_t;

  // core clock domain
  typedef struct packed {
    sspc_cfg_t      cfg;
    logic [3:0]     faultLatch;
    logic [15:0]    statusHold;
    logic           csHighPrev;
    logic           resetPrev;
    logic           in0Prev;
    logic [7:0]     pwmCnt;
    logic           wdRun;
    logic [WDW-1:0] wdCnt;
    logic           wdExpired;
    logic [3:0]     switchOut;
    logic [2:0]     senseSource;
    logic           senseEnable;
    logic           faultOe;
    logic           awake;
  } sspc_core_t;

  sspc_open_t o;
  sspc_open_t next_o;
  sspc_rx_t   r;
  sspc_rx_t   next_r;
  logic       soBit;
  logic       next_soBit;
  sspc_core_t c;
  sspc_core_t next_c;

  logic        firstBit;
  logic [15:0] shiftSrc;
  logic        rxValid;
  logic [7:0]  syncIn;
  logic [7:0]  syncQ;

  // a new tag means no falling edge seen yet in this frame
  assign firstBit = (r.seenTag != o.frameTag);
  assign shiftSrc = firstBit ? o.snap : r.sr;
  assign rxValid  = (r.count == FRAME_FULL);

  // status loaded on select fall, no shift clock needed
  always_comb
  begin
    next_o.snap     = c.statusHold;
    next_o.frameTag = !o.frameTag;
  end

  always_ff @(negedge link.selectLow or negedge arst_n)
  begin
    if (!arst_n)
      o <= '0;
    else
      o <= next_o;
  end

  // input shift; clock edges while deselected leave it alone
  always_comb
  begin
    next_r = r;
    if (!link.selectLow)
    begin
      next_r.sr      = {shiftSrc[14:0], link.si};
      next_r.seenTag = o.frameTag;
      if (firstBit)
        next_r.count = 5'h01;
      else if (r.count <= FRAME_FULL)
        next_r.count = r.count + 5'h01;
    end
  end

  always_ff @(negedge link.sclk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else
      r <= next_r;
  end

  // output bit moves on rising edges; after sixteen bits the
  // received stream itself falls out, which gives daisy chaining
  always_comb
  begin
    next_soBit = soBit;
    if (!link.selectLow)
      next_soBit = shiftSrc[15];
  end

  always_ff @(posedge link.sclk or negedge arst_n)
  begin
    if (!arst_n)
      soBit <= 1'b0;
    else
      soBit <= next_soBit;
  end

  // enable follows select without a clock, else 60 ns is missed
  assign link.soOe   = !link.selectLow;
  assign link.soData = firstBit ? o.snap[15] : soBit;

  // pins and link levels into the core clock
  assign syncIn = {rxValid, link.directInputs, link.wake,
                   link.resetInLow, link.selectLow};

  sspc_sync #(
    .W (8)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (syncIn),
    .q      (syncQ)
  );

  // core: configuration, wake, watchdog, pwm, faults, outputs
  always_comb
  begin
    logic       csHigh;
    logic       resetHigh;
    logic       wakeHigh;
    logic [3:0] dirIn;
    logic       rxOk;
    logic       isAwake;
    logic       commit;
    logic [4:0] addr;
    logic [15:0] word;
    logic       pwmLevel;
    sspc_cfg_t  eff;
    logic [3:0] clearBits;
    csHigh    = syncQ[0];
    resetHigh = syncQ[1];
    wakeHigh  = syncQ[2];
    dirIn     = syncQ[6:3];
    rxOk      = syncQ[7];
    word      = r.sr;
    addr      = word[ADDR_MSB:ADDR_LSB];
    isAwake   = resetHigh | wakeHigh | (|dirIn);
    eff       = isAwake ? c.cfg : '0;
    pwmLevel  = (c.pwmCnt < c.cfg.pwmDuty);
    // word is quiet once select is seen high, so read it as is
    commit    = csHigh & !c.csHighPrev & rxOk & resetHigh;
    clearBits = 4'h0;
    next_c    = c;

    next_c.csHighPrev = csHigh;
    next_c.resetPrev  = resetHigh;
    next_c.in0Prev    = dirIn[0];
    next_c.awake      = isAwake;

    if (commit)
    begin
      unique case (addr)
        ADDR_OUTPUT:
        begin
          next_c.cfg.onBits = word[OUT_ON_LSB +: 4];
          next_c.cfg.directDisable = word[OUT_DIRDIS_LSB +: 4];
          next_c.cfg.pwmEnable = word[OUT_PWMEN_BIT];
        end
        ADDR_SENSE:
        begin
          next_c.cfg.senseSelect = word[SENSE_SEL_LSB +: 3];
          next_c.cfg.senseEnable = word[SENSE_EN_BIT];
        end
        ADDR_PWM:
          next_c.cfg.pwmDuty = word[PWM_DUTY_LSB +: 8];
        ADDR_FAULT_CLR:
          clearBits = word[FAULT_CLR_LSB +: 4];
        default:
          next_c.cfg = c.cfg; // unmapped addresses are dropped
      endcase
    end

    // pwm timebase counts rising edges of input zero
    if (dirIn[0] & !c.in0Prev)
      next_c.pwmCnt = c.pwmCnt + 8'h01;

    // watchdog restarts on reset release, kicked by good frames
    if (resetHigh & !c.resetPrev)
    begin
      next_c.wdRun = 1'b1;
      next_c.wdCnt = '0;
    end
    else if (commit)
      next_c.wdCnt = '0;
    else if (c.wdRun)
    begin
      if (c.wdCnt == WDOG_LAST)
      begin
        next_c.wdRun     = 1'b0;
        next_c.wdExpired = 1'b1;
      end
      else
        next_c.wdCnt = c.wdCnt + WDW'(1);
    end

    // sticky faults: a new fault beats a clear in the same cycle
    next_c.faultLatch = (c.faultLatch & ~clearBits) | faultIn;

    // reset pin low wipes settings, faults and watchdog
    if (!resetHigh)
    begin
      next_c.cfg        = '0;
      next_c.faultLatch = faultIn;
      next_c.wdRun      = 1'b0;
      next_c.wdCnt      = '0;
      next_c.wdExpired  = 1'b0;
    end

    // asleep, every setting behaves as zero
    for (int i = 0; i < 4; i++)
    begin
      next_c.switchOut[i] = isAwake &
        (((dirIn[i] & !eff.directDisable[i]) | eff.onBits[i]) &
          !eff.pwmEnable |
         (eff.onBits[i] & pwmLevel & eff.pwmEnable));
    end
    next_c.senseSource = eff.senseSelect;
    next_c.senseEnable = eff.senseEnable;
    next_c.faultOe     = |c.faultLatch;

    // status refreshed only while deselected
    if (csHigh)
    begin
      next_c.statusHold = '0;
      next_c.statusHold[ST_FAULT_LSB +: 4]  = c.faultLatch;
      next_c.statusHold[ST_SWITCH_LSB +: 4] = c.switchOut;
      next_c.statusHold[ST_DIRECT_LSB +: 4] = dirIn;
      next_c.statusHold[ST_WDOG_BIT]        = c.wdExpired;
      next_c.statusHold[ST_AWAKE_BIT]       = c.awake;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      c <= '0;
    else
      c <= next_c;
  end

  assign switchOutputs       = c.switchOut;
  assign senseSource         = c.senseSource;
  assign senseEnable         = c.senseEnable;
  assign awake               = c.awake;
  assign wdExpired           = c.wdExpired;
  assign link.faultFlagLowOe = c.faultOe;
endmodule // sspc_device

// ===== design/sspc_host.sv
`timescale 1ns/1ps
module sspc_host
  import sspc_pkg::*;
(
  // core clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // link pins
  sspc_if.host             link,
  // frame request
  input  wire logic        reqValid,
  input  wire logic [15:0] reqWord,
  output logic             reqReady,
  // frame answer
  output logic             respValid,
  output logic      [15:0] respWord,
  // pin controls
  input  wire logic        resetReq,
  input  wire logic        wakeIn,
  input  wire logic [3:0]  directIn,
  output logic             faultSeen
);
  import sspc_pkg::*;

  localparam int PHASE_LAST = 2 * SCLK_HALF_CYC - 1;

  typedef enum logic [2:0] {
    H_RESET, H_ENABLE, H_IDLE, H_LEAD, H_SHIFT, H_LAG, H_GAP
  } sspc_hstate_t;

  typedef struct packed {
    sspc_hstate_t st;
    logic [7:0]   cnt;
    logic [3:0]   bitIdx;
    logic [15:0]  txSr;
    logic [15:0]  rxSr;
    logic [1:0]   capPipe;
    logic [4:0]   capCount;
    logic         sclk;
    logic         selLow;
    logic         si;
    logic         rstLow;
    logic         wake;
    logic [3:0]   direct;
    logic         reqReady;
    logic         respValid;
    logic [15:0]  respWord;
    logic         faultSeen;
  } sspc_host_t;

  sspc_host_t s;
  sspc_host_t next_s;
  logic [1:0] syncQ;

  // serial output and fault flag cross from the pins
  sspc_sync #(
    .W (2)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({link.faultFlagLow, link.soLine}),
    .q      (syncQ)
  );

  always_comb
  begin
    logic fallNow;
    next_s           = s;
    next_s.respValid = 1'b0;
    next_s.wake      = wakeIn;
    next_s.direct    = directIn;
    next_s.faultSeen = !syncQ[1];
    fallNow          = 1'b0;

    unique case (s.st)
      H_RESET:
      begin
        next_s.rstLow = 1'b0;
        if (s.cnt == 8'(RESET_LOW_CYC - 1))
        begin
          next_s.rstLow = 1'b1;
          next_s.cnt    = '0;
          next_s.st     = H_ENABLE;
        end
        else
          next_s.cnt = s.cnt + 8'h01;
      end
      H_ENABLE:
      begin
        if (s.cnt == 8'(ENABLE_CYC - 1))
        begin
          next_s.st       = H_IDLE;
          next_s.reqReady = 1'b1;
        end
        else
          next_s.cnt = s.cnt + 8'h01;
      end
      H_IDLE:
      begin
        if (resetReq)
        begin
          next_s.st       = H_RESET;
          next_s.cnt      = '0;
          next_s.reqReady = 1'b0;
          next_s.rstLow   = 1'b0;
        end
        else if (reqValid)
        begin
          next_s.reqReady = 1'b0;
          next_s.txSr     = reqWord;
          next_s.si       = reqWord[15];
          next_s.selLow   = 1'b0;
          next_s.cnt      = '0;
          next_s.capCount = '0;
          next_s.st       = H_LEAD;
        end
      end
      H_LEAD:
      begin
        if (s.cnt == 8'(LEAD_CYC - 1))
        begin
          next_s.sclk   = 1'b1;
          next_s.cnt    = '0;
          next_s.bitIdx = '0;
          next_s.st     = H_SHIFT;
        end
        else
          next_s.cnt = s.cnt + 8'h01;
      end
      H_SHIFT:
      begin
        next_s.cnt = s.cnt + 8'h01;
        // half periods never shorter than the 8 MHz limit allows
        if (s.cnt == 8'(SCLK_HALF_CYC - 1))
        begin
          next_s.sclk = 1'b0;
          fallNow     = 1'b1;
        end
        else if (s.cnt == 8'(PHASE_LAST))
        begin
          next_s.cnt = '0;
          if (s.bitIdx == 4'hf)
            next_s.st = H_LAG;
          else
          begin
            next_s.bitIdx = s.bitIdx + 4'h1;
            next_s.txSr   = {s.txSr[14:0], 1'b0};
            next_s.si     = s.txSr[14];
            next_s.sclk   = 1'b1;
          end
        end
      end
      H_LAG:
      begin
        // clock is low here, so select may rise
        if (s.capCount == FRAME_FULL)
        begin
          next_s.selLow    = 1'b1;
          next_s.respValid = 1'b1;
          next_s.respWord  = s.rxSr;
          next_s.cnt       = '0;
          next_s.st        = H_GAP;
        end
      end
      H_GAP:
      begin
        if (s.cnt == 8'(SELECT_GAP_CYC - 1))
        begin
          next_s.st       = H_IDLE;
          next_s.reqReady = 1'b1;
        end
        else
          next_s.cnt = s.cnt + 8'h01;
      end
    endcase

    // take the output bit two edges after each falling clock
    next_s.capPipe = {s.capPipe[0], fallNow};
    if (s.capPipe[1])
    begin
      next_s.rxSr     = {s.rxSr[14:0], syncQ[0]};
      next_s.capCount = s.capCount + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s        <= '0;
      s.st     <= H_RESET;
      s.selLow <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign link.sclk         = s.sclk;
  assign link.selectLow    = s.selLow;
  assign link.si           = s.si;
  assign link.resetInLow   = s.rstLow;
  assign link.wake         = s.wake;
  assign link.directInputs = s.direct;
  assign reqReady          = s.reqReady;
  assign respValid         = s.respValid;
  assign respWord          = s.respWord;
  assign faultSeen         = s.faultSeen;
endmodule // sspc_host

// ===== design/sspc_sync.sv
`timescale 1ns/1ps
module sspc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         arst_n,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sspc_sync_t;

  sspc_sync_t s;
  sspc_sync_t next_s;

  // first stage feeds only the second
  always_comb
  begin
    next_s.meta = d;
    next_s.q    = s.meta;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign q = s.q;
endmodule // sspc_sync

// ===== dv/sspc_chk.sv
`timescale 1ns/1ps
module sspc_chk
  import sspc_pkg::*;
(
  // core clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link pins
  input wire logic sclk,
  input wire logic selectLow,
  input wire logic soData,
  input wire logic soOe,
  input wire logic resetInLow
);
  logic [15:0] selCnt, hiCnt, rstHi, rstLo;
  logic [4:0]  falls;
  logic        sclkQ;

  // cycle and edge counters; hiCnt, rstHi and rstLo saturate so long idle spans never wrap to zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      selCnt <= 16'h0;
      hiCnt  <= 16'h0;
      rstHi  <= 16'h0;
      rstLo  <= 16'h0;
      falls  <= 5'h0;
      sclkQ  <= 1'b0;
    end
    else
    begin
      selCnt <= selectLow ? 16'h0 : selCnt + 16'h1;
      hiCnt  <= !selectLow ? 16'h0 : hiCnt + 16'(hiCnt != 16'hffff);
      rstHi  <= !resetInLow ? 16'h0 : rstHi + 16'(rstHi != 16'hffff);
      rstLo  <= resetInLow ? 16'h0 : rstLo + 16'(rstLo != 16'hffff);
      falls  <= selectLow ? 5'h0 : falls + 5'(sclkQ & !sclk);
      sclkQ  <= sclk;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_so_on; $fell(selectLow) |-> soOe; endproperty
  a_so_on: assert property (p_so_on)
    else $error("serial output not driven in frame");
  property p_so_off; selectLow |-> !soOe; endproperty
  a_so_off: assert property (p_so_off)
    else $error("serial output driven while deselected");
  property p_sel_edge; $changed(selectLow) |-> !sclk && !$past(sclk);
  endproperty
  a_sel_edge: assert property (p_sel_edge)
    else $error("select moved with shift clock high");
  property p_idle_low; selectLow |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("shift clock high while deselected");
  property p_lead; $rose(sclk) |-> selCnt >= LEAD_CYC; endproperty
  a_lead: assert property (p_lead)
    else $error("shift clock too soon after select");
  property p_gap; $fell(selectLow) |-> hiCnt >= SELECT_GAP_CYC; endproperty
  a_gap: assert property (p_gap)
    else $error("select gap too short");
  property p_enable; $fell(selectLow) |-> rstHi >= ENABLE_CYC; endproperty
  a_enable: assert property (p_enable)
    else $error("frame too soon after reset pin release");
  property p_rst_low; $rose(resetInLow) |-> rstLo >= RESET_LOW_CYC - 1;
  endproperty
  a_rst_low: assert property (p_rst_low)
    else $error("reset pin low too briefly");
  property p_sclk_hi; $rose(sclk) |-> sclk [*2]; endproperty
  a_sclk_hi: assert property (p_sclk_hi)
    else $error("shift clock high phase too short");
  property p_sclk_lo; $fell(sclk) && !selectLow |-> !sclk [*2]; endproperty
  a_sclk_lo: assert property (p_sclk_lo)
    else $error("shift clock low phase too short");
  property p_bits; $rose(selectLow) |-> falls == FRAME_FULL; endproperty
  a_bits: assert property (p_bits)
    else $error("frame length not sixteen bits");
  property p_so_step;
    !selectLow && selCnt > 16'h4 && $changed(soData) |-> $rose(sclk);
  endproperty
  a_so_step: assert property (p_so_step)
    else $error("serial output moved off a rising edge");
endmodule // sspc_chk

// ===== dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import sspc_pkg::*;
  logic        clk, arst_n, reqValid, resetReq, wakeIn;
  logic        reqReady, respValid, faultSeen, senseEnable, awake, wdExpired;
  logic [15:0] reqWord, respWord, r;
  logic [3:0]  directIn, faultIn, switchOutputs, on, din, f;
  logic [2:0]  senseSource;
  integer      seed = 32'he9dc;
  int          badCount = 0, nChecks = 0, n;

  sspc_if link_if ();
  sspc_host sspc_host_inst (.clk(clk), .arst_n(arst_n), .link(link_if),
    .reqValid(reqValid), .reqWord(reqWord), .reqReady(reqReady),
    .respValid(respValid), .respWord(respWord), .resetReq(resetReq),
    .wakeIn(wakeIn), .directIn(directIn), .faultSeen(faultSeen));
  // short watchdog keeps the expiry check inside a few frames
  sspc_device #(.WDOG_CYCLES(64)) sspc_device_inst (.clk(clk),
    .arst_n(arst_n), .link(link_if), .faultIn(faultIn),
    .switchOutputs(switchOutputs), .senseSource(senseSource),
    .senseEnable(senseEnable), .awake(awake), .wdExpired(wdExpired));
  sspc_chk chk_inst (.clk(clk), .arst_n(arst_n), .sclk(link_if.sclk),
    .selectLow(link_if.selectLow), .soData(link_if.soData),
    .soOe(link_if.soOe), .resetInLow(link_if.resetInLow));

  // free-running core clock
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    nChecks++;
    if (g !== e)
    begin
      badCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask

  // request held from a falling edge until the take edge
  task automatic frame(input logic [15:0] w, output logic [15:0] q);
    int k;
    k = 0;
    while (reqReady !== 1'b1 && k < 2000)
    begin
      @(negedge clk);
      k++;
    end
    chk("ready", 16'h1, {15'h0, reqReady});
    reqWord  = w;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    k = 0;
    while (respValid !== 1'b1 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
    chk("answer", 16'h1, {15'h0, respValid});
    q = respWord;
  endtask

  // commit lands a few edges after select rises
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    logic [15:0] x;
    frame({a, d}, x);
    cyc(6);
  endtask

  function automatic logic [15:0] stat(logic [3:0] fl, sw, di, logic wd);
    return {fl, sw, di, wd, 1'b1, 2'b00};
  endfunction

  // main sequence
  initial
  begin
    {arst_n, reqValid, reqWord, resetReq, wakeIn, directIn, faultIn} = '0;
    cyc(3);
    arst_n = 1'b1;
    chk("released", 16'h0, {15'h0, link_if.soOe});
    for (int i = 0; i < 4; i++)
    begin
      on = (i == 0) ? 4'hf : 4'($random(seed));
      din = (i == 0) ? 4'h0 : 4'($random(seed));
      directIn = din;
      wakeIn = 1'b1;
      wr(ADDR_OUTPUT, {3'h0, 4'hf, on});
      chk("switch", {12'h0, on}, {12'h0, switchOutputs});
      frame({ADDR_OUTPUT ^ 5'h10, 11'($random(seed))}, r);
      chk("status", stat(4'h0, on, din, 1'b1), r & 16'hfffc);
      cyc(6);
      chk("unmapped", {12'h0, on}, {12'h0, switchOutputs});
    end
    wakeIn = 1'b0;
    wr(ADDR_OUTPUT, 11'h0);
    din = 4'($random(seed)) | 4'h1;
    directIn = din;
    cyc(6);
    chk("direct", {12'h0, din}, {12'h0, switchOutputs});
    chk("awake", 16'h1, {15'h0, awake});
    for (int s = 0; s < 5; s++)
    begin
      wr(ADDR_SENSE, {7'h0, 1'b1, 3'(s)});
      chk("sense src", 16'(s), {13'h0, senseSource});
      chk("sense on", 16'h1, {15'h0, senseEnable});
    end
    wr(ADDR_SENSE, {8'h0, SENSE_TEMP});
    chk("sense off", 16'h0, {15'h0, senseEnable});
    directIn = 4'h0;
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_PWM, {3'h0, (k == 1) ? 8'hff : 8'h00});
      wr(ADDR_OUTPUT, 11'h10f);
      repeat (3)
      begin
        directIn[0] = 1'b1;
        cyc(4);
        directIn[0] = 1'b0;
        cyc(4);
      end
      chk("pwm", (k == 1) ? 16'hf : 16'h0, {12'h0, switchOutputs});
    end
    // fault latch, flag and serial report
    f = 4'($random(seed)) | 4'h8;
    faultIn = f;
    cyc(6);
    chk("fault seen", 16'h1, {15'h0, faultSeen});
    chk("fault pin", 16'h0, {15'h0, link_if.faultFlagLow});
    frame({5'h1f, 11'h0}, r);
    chk("fault bits", {12'h0, f}, {12'h0, r[15:12]});
    faultIn = 4'h0;
    wr(ADDR_FAULT_CLR, 11'hf);
    cyc(4);
    chk("fault clear", 16'h0, {15'h0, faultSeen});
    // reset pin: sleep, clear, wake input, watchdog start
    wr(ADDR_OUTPUT, 11'h0ff);
    resetReq = 1'b1;
    n = 0;
    while (link_if.resetInLow !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    chk("reset low", 16'h0, {15'h0, link_if.resetInLow});
    resetReq = 1'b0;
    cyc(10);
    chk("asleep", 16'h0, {15'h0, awake});
    chk("sleep out", 16'h0, {12'h0, switchOutputs});
    chk("wd clear", 16'h0, {15'h0, wdExpired});
    wakeIn = 1'b1;
    cyc(6);
    chk("wake pin", 16'h1, {15'h0, awake});
    chk("cleared", 16'h0, {12'h0, switchOutputs});
    // reset pin still low: only a direct input keeps it awake
    wakeIn = 1'b0;
    directIn = din;
    cyc(6);
    chk("in wake", 16'h1, {15'h0, awake});
    chk("in drive", {12'h0, din}, {12'h0, switchOutputs});
    n = 0;
    while (link_if.resetInLow !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("reset high", 16'h1, {15'h0, link_if.resetInLow});
    cyc(10);
    chk("wd early", 16'h0, {15'h0, wdExpired});
    cyc(70);
    chk("wd late", 16'h1, {15'h0, wdExpired});
    print_verdict();
  end

  // hang guard, several times the expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    badCount++;
    print_verdict();
  end
endmodule // tb_top

// ===== include/sspc_if.sv
`timescale 1ns/1ps
interface sspc_if;
  logic       sclk;
  logic       selectLow;
  logic       si;
  logic       soData;
  logic       soOe;
  logic       resetInLow;
  logic       wake;
  logic [3:0] directInputs;
  logic       faultFlagLowOe;
  logic       faultFlagLow;
  logic       soLine;

  // open-drain flag with pull-up; released serial output reads low
  assign faultFlagLow = !faultFlagLowOe;
  assign soLine       = soOe & soData;

  modport device (
    input  sclk, selectLow, si, resetInLow, wake, directInputs,
    output soData, soOe, faultFlagLowOe
  );
  modport host (
    output sclk, selectLow, si, resetInLow, wake, directInputs,
    input  soLine, faultFlagLow
  );
endinterface

// ===== include/sspc_pkg.sv
package sspc_pkg;
  // clock and link timing limits
  localparam int CLK_PERIOD_NS          = 40;
  localparam int SCLK_MAX_KHZ           = 8000;
  localparam int RESET_LOW_MIN_NS       = 10000;
  localparam int SELECT_GAP_MIN_NS      = 1000;
  localparam int RESET_TO_SELECT_MIN_NS = 5000;
  localparam int LEAD_MIN_NS            = 500;
  // least times round up to whole cycles
  localparam int SCLK_HALF_CYC =
    (1000000 / SCLK_MAX_KHZ + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  localparam int RESET_LOW_CYC =
    (RESET_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SELECT_GAP_CYC =
    (SELECT_GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ENABLE_CYC =
    (RESET_TO_SELECT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEAD_CYC =
    (LEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // frame layout
  localparam int FRAME_BITS = 16;
  localparam int ADDR_MSB   = 15;
  localparam int ADDR_LSB   = 11;
  localparam logic [4:0] FRAME_FULL = 5'h10;

  // register addresses carried in the frame
  localparam logic [4:0] ADDR_OUTPUT    = 5'h01;
  localparam logic [4:0] ADDR_SENSE     = 5'h02;
  localparam logic [4:0] ADDR_PWM       = 5'h03;
  localparam logic [4:0] ADDR_FAULT_CLR = 5'h04;

  // data field positions
  localparam int OUT_ON_LSB     = 0;
  localparam int OUT_DIRDIS_LSB = 4;
  localparam int OUT_PWMEN_BIT  = 8;
  localparam int SENSE_SEL_LSB  = 0;
  localparam int SENSE_EN_BIT   = 3;
  localparam int PWM_DUTY_LSB   = 0;
  localparam int FAULT_CLR_LSB  = 0;
  localparam logic [2:0] SENSE_TEMP = 3'h4;

  // status word positions
  localparam int ST_FAULT_LSB  = 12;
  localparam int ST_SWITCH_LSB = 8;
  localparam int ST_DIRECT_LSB = 4;
  localparam int ST_WDOG_BIT   = 3;
  localparam int ST_AWAKE_BIT  = 2;

  // serially configurable settings, all zero at reset
  typedef struct packed {
    logic [3:0] onBits;
    logic [3:0] directDisable;
    logic       pwmEnable;
    logic [2:0] senseSelect;
    logic       senseEnable;
    logic [7:0] pwmDuty;
  } sspc_cfg_t;
endpackage
